// *** design/lps_pkg.sv ***
package lps_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PIN_W     = DATA_W + 5;
  localparam int unsigned LAST_STG  = DATA_W - 1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PIN_W-1:0]  PIN_RST  = 13'h0000;

  // all pin inputs travel together through the synchroniser
  typedef struct packed {
    logic [DATA_W-1:0] par_data;
    logic              serial_in;
    logic              parallel_load_n;
    logic              shift_clear_n;
    logic              shift_clock;
    logic              storage_clock;
  } lps_pins_type;

endpackage

// *** design/lps_shift_top.sv ***
`timescale 1ns/1ps
module lps_shift_top
  import lps_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [DATA_W-1:0] par_data_i,
  input  wire logic              serial_in_i,
  input  wire logic              storage_clock_i,
  input  wire logic              shift_clock_i,
  input  wire logic              parallel_load_n_i,
  input  wire logic              shift_clear_n_i,
  output logic                   serial_out_o
);

  lps_pins_type      pins_raw;
  lps_pins_type      pins_s;
  logic [PIN_W-1:0]  pins_sync;
  logic              store_prev_r;
  logic              store_prev_nxt;
  logic              shift_prev_r;
  logic              shift_prev_nxt;
  logic              store_edge;
  logic              shift_edge;
  logic [DATA_W-1:0] latch_r;
  logic [DATA_W-1:0] latch_nxt;
  logic [DATA_W-1:0] shift_r;
  logic [DATA_W-1:0] shift_nxt;
  logic [DATA_W-1:0] stage_in;

  // pack the pins, bit A lands in bit 0 and H in bit 7
  always_comb begin
    pins_raw.par_data        = par_data_i;
    pins_raw.serial_in       = serial_in_i;
    pins_raw.parallel_load_n = parallel_load_n_i;
    pins_raw.shift_clear_n   = shift_clear_n_i;
    pins_raw.shift_clock     = shift_clock_i;
    pins_raw.storage_clock   = storage_clock_i;
  end

  // every pin passes two flops before any logic reads it; this costs two
  // system clocks of latency but keeps metastability out of the decode
  lps_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   (pins_raw),
    .sync_o    (pins_sync)
  );

  assign pins_s = lps_pins_type'(pins_sync);

  // rising edges of the pin clocks, seen on the system clock
  always_comb begin
    store_prev_nxt = pins_s.storage_clock;
    shift_prev_nxt = pins_s.shift_clock;
    store_edge     = pins_s.storage_clock & ~store_prev_r;
    shift_edge     = pins_s.shift_clock & ~shift_prev_r;
  end

  // storage latch captures on every storage edge, nothing else matters
  always_comb begin
    latch_nxt = latch_r;
    if (store_edge) begin
      latch_nxt = pins_s.par_data;
    end
  end

  // each stage takes its neighbour and stage 0 takes the serial input;
  // the loop keeps the stage order explicit, H being the one that shows
  genvar gs;
  generate
    for (gs = 0; gs < DATA_W; gs++) begin : g_stage
      if (gs == 0) begin : g_first
        assign stage_in[gs] = pins_s.serial_in;
      end else begin : g_next
        assign stage_in[gs] = shift_r[gs-1];
      end
    end
  endgenerate

  // clear and load are levels and win over the shift clock;
  // both low is illegal, clear is taken so the state stays defined
  always_comb begin
    shift_nxt = shift_r;
    if (!pins_s.shift_clear_n) begin
      shift_nxt = DATA_RST;
    end else if (!pins_s.parallel_load_n) begin
      if (store_edge) begin
        shift_nxt = pins_s.par_data;
      end else begin
        shift_nxt = latch_r;
      end
    end else if (shift_edge) begin
      shift_nxt = stage_in;
    end
  end

  // registers; serial output is the last stage flop itself
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      store_prev_r <= 1'b0;
      shift_prev_r <= 1'b0;
      latch_r      <= DATA_RST;
      shift_r      <= DATA_RST;
    end else begin
      store_prev_r <= store_prev_nxt;
      shift_prev_r <= shift_prev_nxt;
      latch_r      <= latch_nxt;
      shift_r      <= shift_nxt;
    end
  end

  assign serial_out_o = shift_r[LAST_STG];

  // the checks see the synchronised pins, the same view the logic decodes
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // latch only moves on a storage edge
  property p_latch_hold;
    !store_edge |=> latch_r == $past(latch_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without storage edge");

  // storage edge captures the parallel pins
  property p_latch_cap;
    store_edge |=> latch_r == $past(pins_s.par_data);
  endproperty
  a_latch_cap: assert property (p_latch_cap) else $error("latch missed parallel data");

  // storage edge still captures while clear holds the register
  property p_latch_when_clear;
    store_edge && !pins_s.shift_clear_n |=> latch_r == $past(pins_s.par_data);
  endproperty
  a_latch_when_clear: assert property (p_latch_when_clear) else $error("latch missed data during clear");

  // direct load takes the pins, not the stale latch
  property p_load_direct;
    store_edge && !pins_s.parallel_load_n && pins_s.shift_clear_n |=> shift_r == $past(pins_s.par_data);
  endproperty
  a_load_direct: assert property (p_load_direct) else $error("shift reg missed direct load");

  // after a direct load latch and register agree
  property p_latch_over_load;
    store_edge && !pins_s.parallel_load_n && pins_s.shift_clear_n |=> latch_r == shift_r;
  endproperty
  a_latch_over_load: assert property (p_latch_over_load) else $error("latch and register differ");

  // storage edge with load high leaves the register alone
  property p_latch_only;
    store_edge && pins_s.parallel_load_n && pins_s.shift_clear_n && !shift_edge |=> $stable(shift_r);
  endproperty
  a_latch_only: assert property (p_latch_only) else $error("storage edge disturbed register");

  // load level keeps the register on the latch
  property p_load_latch;
    !store_edge && !pins_s.parallel_load_n && pins_s.shift_clear_n |=> shift_r == $past(latch_r);
  endproperty
  a_load_latch: assert property (p_load_latch) else $error("shift reg missed latch load");

  // a shift edge during load is ignored
  property p_load_over_shift;
    !pins_s.parallel_load_n && pins_s.shift_clear_n && !store_edge && shift_edge |=> shift_r == $past(latch_r);
  endproperty
  a_load_over_shift: assert property (p_load_over_shift) else $error("shift edge broke through load");

  // clear with load high empties the register
  property p_clear;
    !pins_s.shift_clear_n && pins_s.parallel_load_n |=> shift_r == DATA_RST && !serial_out_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero register");

  // clear beats the shift clock, in the illegal both-low case too
  property p_clear_over_shift;
    !pins_s.shift_clear_n && shift_edge |=> shift_r == DATA_RST;
  endproperty
  a_clear_over_shift: assert property (p_clear_over_shift) else $error("shift edge broke through clear");

  // one shift step moves every stage up by one
  property p_shift;
    pins_s.parallel_load_n && pins_s.shift_clear_n && shift_edge
      |=> shift_r == {$past(shift_r[LAST_STG-1:0]), $past(pins_s.serial_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift step wrong");

  // stage 0 takes the serial input
  property p_serial_first;
    pins_s.parallel_load_n && pins_s.shift_clear_n && shift_edge |=> shift_r[0] == $past(pins_s.serial_in);
  endproperty
  a_serial_first: assert property (p_serial_first) else $error("first stage missed serial input");

  // no edge, no load, no clear: register holds
  property p_idle;
    pins_s.parallel_load_n && pins_s.shift_clear_n && !shift_edge |=> $stable(shift_r);
  endproperty
  a_idle: assert property (p_idle) else $error("shift reg moved while idle");

  // serial output shows the next stage after a shift
  property p_out_msb;
    pins_s.parallel_load_n && pins_s.shift_clear_n && shift_edge |=> serial_out_o == $past(shift_r[LAST_STG-1]);
  endproperty
  a_out_msb: assert property (p_out_msb) else $error("serial output not next stage");

  // serial output follows a latch load in the same step
  property p_out_load;
    !pins_s.parallel_load_n && pins_s.shift_clear_n && !store_edge |=> serial_out_o == $past(latch_r[LAST_STG]);
  endproperty
  a_out_load: assert property (p_out_load) else $error("serial output lagged load");

  // serial output shows bit H right after a direct load
  property p_direct_out;
    store_edge && !pins_s.parallel_load_n && pins_s.shift_clear_n
      |=> serial_out_o == $past(pins_s.par_data[LAST_STG]);
  endproperty
  a_direct_out: assert property (p_direct_out) else $error("serial output lagged direct load");

  // without an action the serial output stands
  property p_out_quiet;
    pins_s.parallel_load_n && pins_s.shift_clear_n && !shift_edge |=> $stable(serial_out_o);
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("serial output moved while idle");

  // main scenarios: shift, both loads, clear and a plain storage edge
  c_shift: cover property (pins_s.parallel_load_n && pins_s.shift_clear_n && shift_edge);
  c_load_latch: cover property (!pins_s.parallel_load_n && pins_s.shift_clear_n && !store_edge);
  c_load_direct: cover property (store_edge && !pins_s.parallel_load_n && pins_s.shift_clear_n);
  c_clear: cover property (!pins_s.shift_clear_n && pins_s.parallel_load_n);
  c_latch_only: cover property (store_edge && pins_s.parallel_load_n);

endmodule // lps_shift_top

// *** design/lps_sync.sv ***
`timescale 1ns/1ps
module lps_sync
  import lps_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [PIN_W-1:0] async_i,
  output logic      [PIN_W-1:0] sync_o
);

  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] meta_nxt;
  logic [PIN_W-1:0] sync_r;
  logic [PIN_W-1:0] sync_nxt;

  // two flops per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_bit
      always_comb begin
        meta_nxt[gi] = async_i[gi];
        sync_nxt[gi] = meta_r[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_r <= PIN_RST;
      sync_r <= PIN_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule // lps_sync

// *** verif/lps_host.sv ***
`timescale 1ns/1ps
module lps_host
  import lps_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire lps_pins_type cmd_i,
  output lps_pins_type      pins_o
);
  lps_pins_type safe_pins;

  // load backs off while clear is low, so the illegal pair never reaches the pins
  always_comb begin
    safe_pins = cmd_i;
    safe_pins.parallel_load_n = cmd_i.parallel_load_n | ~cmd_i.shift_clear_n;
  end

  // pins launch one edge after the command, all fields in one assignment
  always_ff @(posedge sys_clk_i) begin
    pins_o <= safe_pins;
  end
endmodule // lps_host

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import lps_pkg::*;;
  logic              sys_clk_i;
  logic              reset_i;
  logic              so;
  lps_pins_type      cmd;
  lps_pins_type      pins;
  logic [DATA_W-1:0] exp_sr;
  logic [DATA_W-1:0] last_sr;
  int                failures = 0;
  int                comparisons = 0;
  int                cyc = 0;

  lps_host host (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .pins_o(pins));
  lps_shift_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .par_data_i(pins.par_data),
    .serial_in_i(pins.serial_in), .storage_clock_i(pins.storage_clock), .shift_clock_i(pins.shift_clock),
    .parallel_load_n_i(pins.parallel_load_n), .shift_clear_n_i(pins.shift_clear_n), .serial_out_o(so));

  // free-running system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic seen, input logic want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // reference shift step: every stage takes its neighbour, stage 0 the serial bit
  function automatic logic [DATA_W-1:0] next_sr(input logic [DATA_W-1:0] sr, input logic b);
    return {sr[LAST_STG-1:0], b};
  endfunction

  // one pin step; the output must still be old just before the answer edge and
  // new just after it, which also catches a late or stale load
  task automatic drive(input lps_pins_type v);
    @(posedge sys_clk_i) cmd <= v;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(so, last_sr[LAST_STG]);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(so, exp_sr[LAST_STG]);
    repeat (2) @(posedge sys_clk_i);
    last_sr = exp_sr;
  endtask

  // hang guard: whole run needs well under this
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  // clear, latch, load from latch, direct load, then shift out
  initial begin
    lps_pins_type      v;
    logic [DATA_W-1:0] d;
    logic              b;
    v = '{8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    cmd = v;
    exp_sr = DATA_RST;
    last_sr = DATA_RST;
    reset_i = 1'b1;
    void'($urandom(29953));
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
      v.shift_clear_n = 1'b0;
      exp_sr = 8'h00;
      drive(v);
      v.shift_clock = 1'b1;
      v.storage_clock = 1'b1;
      drive(v);
      v.shift_clock = 1'b0;
      v.storage_clock = 1'b0;
      v.shift_clear_n = 1'b1;
      v.par_data = d;
      drive(v);
      v.storage_clock = 1'b1;
      drive(v);
      v.storage_clock = 1'b0;
      v.par_data = ~d;
      drive(v);
      v.parallel_load_n = 1'b0;
      exp_sr = d;
      drive(v);
      v.shift_clock = 1'b1;
      drive(v);
      v.shift_clock = 1'b0;
      v.storage_clock = 1'b1;
      exp_sr = ~d;
      drive(v);
      v.storage_clock = 1'b0;
      v.parallel_load_n = 1'b1;
      drive(v);
      for (int k = 0; k < DATA_W + 2; k++) begin
        b = 1'($urandom);
        v.serial_in = b;
        drive(v);
        v.shift_clock = 1'b1;
        exp_sr = next_sr(exp_sr, b);
        drive(v);
        v.shift_clock = 1'b0;
        drive(v);
      end
    end
    // a second reset in mid-run must empty the register without a false edge
    @(posedge sys_clk_i) reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    exp_sr = DATA_RST;
    last_sr = DATA_RST;
    @(negedge sys_clk_i);
    check(so, exp_sr[LAST_STG]);
    drive(v);
    close_out();
  end
endmodule // tb_top
